// >>> src/tcc_pkg.sv
// constants for the 16-bit timer counter with one capture/compare channel
// assumes an AHB-Lite slave with word-aligned 8-bit registers
package tcc_pkg;

  // register byte addresses
  localparam logic [7:0] TCC_OFS_TCS  = 8'h00;  // timer_ctrl_stat
  localparam logic [7:0] TCC_OFS_CNTH = 8'h04;  // count_high
  localparam logic [7:0] TCC_OFS_CNTL = 8'h08;  // count_low
  localparam logic [7:0] TCC_OFS_MODH = 8'h0c;  // modulo_high
  localparam logic [7:0] TCC_OFS_MODL = 8'h10;  // modulo_low
  localparam logic [7:0] TCC_OFS_CCS  = 8'h14;  // chan_ctrl_stat
  localparam logic [7:0] TCC_OFS_CVH  = 8'h18;  // chan_value_high
  localparam logic [7:0] TCC_OFS_CVL  = 8'h1c;  // chan_value_low

  // timer_ctrl_stat fields
  localparam int TCC_TCS_TOF  = 7;
  localparam int TCC_TCS_OVERFLOW_IRQ_EN = 6;
  localparam int TCC_TCS_CAS  = 5;
  localparam int TCC_TCS_CLK  = 3;  // two bits, 4:3

  // chan_ctrl_stat fields
  localparam int TCC_CCS_FLAG = 7;
  localparam int TCC_CCS_MSB  = 5;
  localparam int TCC_CCS_MSA  = 4;
  localparam int TCC_CCS_ELS  = 2;  // two bits, 3:2

  // clock source select codes
  localparam logic [1:0] TCC_CLK_OFF = 2'h0;
  localparam logic [1:0] TCC_CLK_BUS = 2'h1;
  localparam logic [1:0] TCC_CLK_FIX = 2'h2;
  localparam logic [1:0] TCC_CLK_EXT = 2'h3;

  // edge select codes
  localparam logic [1:0] TCC_EDGE_OFF  = 2'h0;
  localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCC_EDGE_FALL = 2'h2;
  localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;

  localparam logic [15:0] TCC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TCC_CNT_FULL = 16'hffff;
  localparam logic [15:0] TCC_CNT_ONE  = 16'h0001;
  localparam logic [7:0]  TCC_BYTE_RST = 8'h00;
  localparam logic [31:0] TCC_WORD_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    TCC_BUS_IDLE   = 2'b01,
    TCC_BUS_ACCESS = 2'b10
  } tcc_bus_st_t;

endpackage : tcc_pkg

// >>> src/tcc_core.sv
// timer counter core: 16-bit counter, overflow flag, one capture channel
// assumes a single AHB-Lite master; chan_pin is asynchronous to hclk
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - capture mode: reading one value byte freezes both until the other is read
// - any chan_ctrl_stat write releases value read and write buffers
// - capture mode ignores software writes to value bytes
// - debug halt freezes read-buffer state; only chan_ctrl_stat write resets it
// - debug halt reads return live value, not the buffer
// - compare/pwm with clock off: load value when second byte written
// - compare with clock on: load at next counter tick after both bytes
// - pwm with clock on: load when counter steps modulus-1 to modulus
// - value bytes may be written high first or low first
// - debug halt writes go straight into the channel value
// - debug halt writes leave a partial write sequence intact
// - center_align_sel 1 makes the channel pwm and counter up/down
// - clock select: 00 off, 01 bus, 10 fixed, 11 external pin
// - clock select resets to 00; 00 stops counting, keeps contents
// - overflow request is a level: flag and enable both set
// - up mode sets overflow flag on wrap from terminal count to zero
// - up/down mode sets overflow flag stepping down from modulus
// - up mode counts zero to terminal count, then zero again
// - up/down mode counts up to terminal, down to zero, ends once each
// - writing either count byte clears counter and its read buffer
// - active capture edge copies counter to value, sets flag, also halted
// - edge select: 01 rising, 10 falling, 11 both, 00 disconnected
// - event flag clears by read-while-set then write 0; new event wins
module tcc_core (
  // bus clock and reset
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // ahb-lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic        hreadyout,
  output var   logic        hresp,
  output var   logic [31:0] hrdata,
  // timer side
  input  wire  logic        chan_pin,
  input  wire  logic        fixed_clk_tick,
  input  wire  logic        debug_halt_mode,
  output var   logic        overflow_irq,
  output var   logic        chan_irq
);
  import tcc_pkg::*;

  // ********************
  // bus slave
  // ********************
  tcc_bus_st_t bus_st_q;
  logic [7:0]  addr_q;
  logic        write_q;
  logic        rdy_q;
  logic [31:0] rdata_q;
  logic        acc;
  logic        rd;
  logic        wr;
  logic [7:0]  wbyte;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_q <= TCC_BUS_IDLE;
      addr_q   <= TCC_BYTE_RST;
      write_q  <= 1'b0;
      rdy_q    <= 1'b1;
    end else begin
      case (bus_st_q)
        TCC_BUS_IDLE: begin
          // one wait state keeps read side effects after any prior write
          if (hsel && htrans[1] && hready) begin
            bus_st_q <= TCC_BUS_ACCESS;
            addr_q   <= haddr[7:0];
            write_q  <= hwrite;
            rdy_q    <= 1'b0;
          end
        end
        TCC_BUS_ACCESS: begin
          bus_st_q <= TCC_BUS_IDLE;
          rdy_q    <= 1'b1;
        end
        default: begin
          bus_st_q <= TCC_BUS_IDLE;
          rdy_q    <= 1'b1;
        end
      endcase
    end
  end

  assign acc   = (bus_st_q == TCC_BUS_ACCESS);
  assign rd    = acc && !write_q;
  assign wr    = acc && write_q;
  assign wbyte = hwdata[7:0];
  assign hreadyout = rdy_q;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // register state
  logic [1:0]  clk_sel_q;
  logic        cas_q;
  logic        overflow_irq_en_q;
  logic        tof_q;
  logic        tof_arm_q;
  logic [15:0] cnt_q;
  logic [15:0] mod_q;
  logic        up_q;
  logic        msb_q;
  logic        msa_q;
  logic [1:0]  els_q;
  logic        flag_q;
  logic        flag_arm_q;
  logic [15:0] cval_q;

  logic wr_tcs, wr_cnt, wr_ccs, wr_cvh, wr_cvl, rd_cvh, rd_cvl;
  logic rd_cnth, rd_cntl;
  assign wr_tcs  = wr && (addr_q == TCC_OFS_TCS);
  assign wr_cnt  = wr && (addr_q == TCC_OFS_CNTH || addr_q == TCC_OFS_CNTL);
  assign wr_ccs  = wr && (addr_q == TCC_OFS_CCS);
  assign wr_cvh  = wr && (addr_q == TCC_OFS_CVH);
  assign wr_cvl  = wr && (addr_q == TCC_OFS_CVL);
  assign rd_cvh  = rd && (addr_q == TCC_OFS_CVH);
  assign rd_cvl  = rd && (addr_q == TCC_OFS_CVL);
  assign rd_cnth = rd && (addr_q == TCC_OFS_CNTH);
  assign rd_cntl = rd && (addr_q == TCC_OFS_CNTL);

  // channel modes
  logic cap_mode, oc_mode, pwm_mode, halted;
  assign cap_mode = !cas_q && !msb_q && !msa_q;
  assign oc_mode  = !cas_q && !msb_q && msa_q;
  assign pwm_mode = cas_q || msb_q;
  assign halted   = debug_halt_mode;

  // ********************
  // pin synchroniser
  // ********************
  logic [2:0] pin_s_q;
  logic       pin_f_q;
  logic       pin_f_d;
  logic       rise, fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s_q <= 3'h0;
      pin_f_q <= 1'b0;
    end else begin
      pin_s_q <= {pin_s_q[1:0], chan_pin};
      pin_f_q <= pin_f_d;
    end
  end

  // a change counts only when the last two stages agree
  assign pin_f_d = (pin_s_q[1] == pin_s_q[2]) ? pin_s_q[2] : pin_f_q;
  assign rise    = pin_f_d && !pin_f_q;
  assign fall    = !pin_f_d && pin_f_q;

  // ********************
  // counter
  // ********************
  logic        tick;
  logic [15:0] term;
  logic        wrap_up, turn_dn;

  always_comb begin
    case (clk_sel_q)
      TCC_CLK_BUS: tick = 1'b1;
      TCC_CLK_FIX: tick = fixed_clk_tick;
      TCC_CLK_EXT: tick = rise;
      default:     tick = 1'b0;
    endcase
    if (halted) begin
      tick = 1'b0;
    end
  end

  assign term    = (mod_q == TCC_CNT_ZERO) ? TCC_CNT_FULL : mod_q;
  assign wrap_up = tick && !cas_q && (cnt_q == term);
  assign turn_dn = tick && cas_q && up_q && (cnt_q == term);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= TCC_CNT_ZERO;
      up_q  <= 1'b1;
    end else if (wr_cnt) begin
      cnt_q <= TCC_CNT_ZERO;
      up_q  <= 1'b1;
    end else if (tick) begin
      if (!cas_q) begin
        cnt_q <= wrap_up ? TCC_CNT_ZERO : cnt_q + TCC_CNT_ONE;
        up_q  <= 1'b1;
      end else if (up_q) begin
        // both ends last one tick: reverse on the tick after reaching them
        if (cnt_q == term) begin
          cnt_q <= cnt_q - TCC_CNT_ONE;
          up_q  <= 1'b0;
        end else begin
          cnt_q <= cnt_q + TCC_CNT_ONE;
        end
      end else if (cnt_q == TCC_CNT_ZERO) begin
        cnt_q <= cnt_q + TCC_CNT_ONE;
        up_q  <= 1'b1;
      end else begin
        cnt_q <= cnt_q - TCC_CNT_ONE;
      end
    end
  end

  // timer control, modulo
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel_q <= TCC_CLK_OFF;
      cas_q     <= 1'b0;
      overflow_irq_en_q    <= 1'b0;
      mod_q     <= TCC_CNT_ZERO;
    end else begin
      if (wr_tcs) begin
        clk_sel_q <= wbyte[TCC_TCS_CLK +: 2];
        cas_q     <= wbyte[TCC_TCS_CAS];
        overflow_irq_en_q    <= wbyte[TCC_TCS_OVERFLOW_IRQ_EN];
      end
      if (wr && addr_q == TCC_OFS_MODH) begin
        mod_q[15:8] <= wbyte;
      end
      if (wr && addr_q == TCC_OFS_MODL) begin
        mod_q[7:0] <= wbyte;
      end
    end
  end

  // overflow flag: read-while-set then write 0, a new overflow wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tof_q     <= 1'b0;
      tof_arm_q <= 1'b0;
    end else if (wrap_up || turn_dn) begin
      tof_q     <= 1'b1;
      tof_arm_q <= 1'b0;
    end else if (rd && addr_q == TCC_OFS_TCS && tof_q) begin
      tof_arm_q <= 1'b1;
    end else if (wr_tcs && tof_arm_q && !wbyte[TCC_TCS_TOF]) begin
      tof_q     <= 1'b0;
      tof_arm_q <= 1'b0;
    end
  end

  // count read coherency
  logic       cnt_lat_q;
  logic [7:0] cnt_buf_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_lat_q <= 1'b0;
      cnt_buf_q <= TCC_BYTE_RST;
    end else if (wr_cnt) begin
      cnt_lat_q <= 1'b0;
    end else if ((rd_cnth || rd_cntl) && !halted) begin
      cnt_lat_q <= !cnt_lat_q;
      cnt_buf_q <= rd_cnth ? cnt_q[7:0] : cnt_q[15:8];
    end
  end

  // ********************
  // channel
  // ********************
  logic cap_evt, cmp_evt;
  assign cap_evt = cap_mode && (
                   (els_q == TCC_EDGE_RISE && rise) ||
                   (els_q == TCC_EDGE_FALL && fall) ||
                   (els_q == TCC_EDGE_BOTH && (rise || fall)));
  assign cmp_evt = !cap_mode && (els_q != TCC_EDGE_OFF) && tick &&
                   (cnt_q == cval_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msb_q <= 1'b0;
      msa_q <= 1'b0;
      els_q <= TCC_EDGE_OFF;
    end else if (wr_ccs) begin
      msb_q <= wbyte[TCC_CCS_MSB];
      msa_q <= wbyte[TCC_CCS_MSA];
      els_q <= wbyte[TCC_CCS_ELS +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q     <= 1'b0;
      flag_arm_q <= 1'b0;
    end else if (cap_evt || cmp_evt) begin
      flag_q     <= 1'b1;
      flag_arm_q <= 1'b0;
    end else if (rd && addr_q == TCC_OFS_CCS && flag_q) begin
      flag_arm_q <= 1'b1;
    end else if (wr_ccs && flag_arm_q && !wbyte[TCC_CCS_FLAG]) begin
      flag_q     <= 1'b0;
      flag_arm_q <= 1'b0;
    end
  end

  // write buffer
  logic [15:0] wb_q;
  logic        got_h_q, got_l_q, pend_q;
  logic        buf_wr, done_h, done_l, both, load_now, load_tick;
  assign buf_wr   = !cap_mode && !halted;
  assign done_h   = got_h_q || (buf_wr && wr_cvh);
  assign done_l   = got_l_q || (buf_wr && wr_cvl);
  assign both     = buf_wr && (wr_cvh || wr_cvl) && done_h && done_l;
  assign load_now = both && clk_sel_q == TCC_CLK_OFF;
  assign load_tick = pend_q && tick && (oc_mode ||
                     (pwm_mode && up_q && cnt_q == term - TCC_CNT_ONE));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wb_q    <= TCC_CNT_ZERO;
      got_h_q <= 1'b0;
      got_l_q <= 1'b0;
      pend_q  <= 1'b0;
    end else if (wr_ccs) begin
      got_h_q <= 1'b0;
      got_l_q <= 1'b0;
      pend_q  <= 1'b0;
    end else if (load_tick) begin
      got_h_q <= 1'b0;
      got_l_q <= 1'b0;
      pend_q  <= 1'b0;
    end else if (buf_wr) begin
      if (wr_cvh) begin
        wb_q[15:8] <= wbyte;
      end
      if (wr_cvl) begin
        wb_q[7:0] <= wbyte;
      end
      if (both) begin
        got_h_q <= 1'b0;
        got_l_q <= 1'b0;
        pend_q  <= !load_now;
      end else begin
        got_h_q <= done_h;
        got_l_q <= done_l;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cval_q <= TCC_CNT_ZERO;
    end else if (cap_evt) begin
      cval_q <= cnt_q;
    end else if (cap_mode) begin
      cval_q <= cval_q;
    end else if (halted && wr_cvh) begin
      cval_q[15:8] <= wbyte;
    end else if (halted && wr_cvl) begin
      cval_q[7:0] <= wbyte;
    end else if (load_now) begin
      cval_q <= {wr_cvh ? wbyte : wb_q[15:8], wr_cvl ? wbyte : wb_q[7:0]};
    end else if (load_tick) begin
      cval_q <= wb_q;
    end
  end

  // value read coherency
  logic       cv_lat_q;
  logic [7:0] cv_buf_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cv_lat_q <= 1'b0;
      cv_buf_q <= TCC_BYTE_RST;
    end else if (wr_ccs) begin
      cv_lat_q <= 1'b0;
    end else if ((rd_cvh || rd_cvl) && cap_mode && !halted) begin
      cv_lat_q <= !cv_lat_q;
      if (!cv_lat_q) begin
        cv_buf_q <= rd_cvh ? cval_q[7:0] : cval_q[15:8];
      end
    end
  end

  // ********************
  // read data and requests
  // ********************
  logic [7:0] rbyte;
  logic       use_cv_buf;
  assign use_cv_buf = cv_lat_q && cap_mode && !halted;

  always_comb begin
    rbyte = TCC_BYTE_RST;
    if (addr_q == TCC_OFS_TCS) begin
      rbyte = {tof_q, overflow_irq_en_q, cas_q, clk_sel_q, 3'h0};
    end else if (addr_q == TCC_OFS_CNTH) begin
      rbyte = (cnt_lat_q && !halted) ? cnt_buf_q : cnt_q[15:8];
    end else if (addr_q == TCC_OFS_CNTL) begin
      rbyte = (cnt_lat_q && !halted) ? cnt_buf_q : cnt_q[7:0];
    end else if (addr_q == TCC_OFS_MODH) begin
      rbyte = mod_q[15:8];
    end else if (addr_q == TCC_OFS_MODL) begin
      rbyte = mod_q[7:0];
    end else if (addr_q == TCC_OFS_CCS) begin
      rbyte = {flag_q, 1'b0, msb_q, msa_q, els_q, 2'h0};
    end else if (addr_q == TCC_OFS_CVH) begin
      rbyte = use_cv_buf ? cv_buf_q : cval_q[15:8];
    end else if (addr_q == TCC_OFS_CVL) begin
      rbyte = use_cv_buf ? cv_buf_q : cval_q[7:0];
    end
  end

  logic irq_q, cirq_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= TCC_WORD_RST;
      irq_q   <= 1'b0;
      cirq_q  <= 1'b0;
    end else begin
      if (rd) begin
        rdata_q <= {24'h000000, rbyte};
      end
      irq_q  <= tof_q && overflow_irq_en_q;
      cirq_q <= flag_q;
    end
  end
  assign overflow_irq = irq_q;
  assign chan_irq     = cirq_q;

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_val_complete;
    both && clk_sel_q == TCC_CLK_OFF;
  endsequence

  a_up_wrap_flag: assert property (wrap_up && !wr_cnt |=> tof_q && cnt_q == TCC_CNT_ZERO) else $error("up wrap missed");
  a_dn_turn_flag: assert property (turn_dn && !wr_cnt |=> tof_q && !up_q && cnt_q == $past(term) - TCC_CNT_ONE) else $error("turn missed");
  a_irq_level: assert property (##1 overflow_irq == $past(tof_q && overflow_irq_en_q)) else $error("irq level wrong");
  a_off_holds: assert property (clk_sel_q == TCC_CLK_OFF && !wr_cnt |=> $stable(cnt_q)) else $error("counter moved while off");
  a_cnt_clear: assert property (wr_cnt |=> cnt_q == TCC_CNT_ZERO && !cnt_lat_q) else $error("count not cleared");
  a_cap_copy: assert property (cap_evt |=> cval_q == $past(cnt_q) && flag_q) else $error("capture wrong");
  a_cap_ro: assert property (cap_mode && !cap_evt |=> $stable(cval_q)) else $error("capture value written");
  a_dbg_frozen: assert property (halted && !wr_ccs |=> $stable(cv_lat_q)) else $error("read latch moved in halt");
  a_ccs_release: assert property (wr_ccs |=> !cv_lat_q && !pend_q && !got_h_q && !got_l_q) else $error("buffers kept");
  a_val_load: assert property (s_val_complete |=> cval_q == {$past(done_h && wr_cvh) ? $past(wbyte) : $past(wb_q[15:8]), $past(wr_cvl) ? $past(wbyte) : $past(wb_q[7:0])}) else $error("clock-off load wrong");
  a_flag_event_wins: assert property (cap_evt |=> flag_q ##1 flag_q) else $error("event lost");

endmodule : tcc_core

`default_nettype wire

// >>> test/tcc_pin_model.sv
// pin model for the timer core: capture edges and an external clock
// assumes the core synchronises chan_pin to hclk itself
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model (
  // bus clock paces the pin
  input  wire logic hclk,
  // channel pin
  output var  logic chan_pin
);
  initial chan_pin = 1'b0;

  // ********
  // pin tasks
  // ********
  // level held long enough for the three-flop synchroniser
  task automatic set_level(input logic lvl);
    chan_pin <= lvl;
    repeat (8) @(posedge hclk);
  endtask : set_level

  // two cycles high, two low: never above a quarter of the bus rate
  task automatic ext_clock(input int n);
    repeat (n) begin
      chan_pin <= 1'b1;
      repeat (2) @(posedge hclk);
      chan_pin <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask : ext_clock
endmodule : tcc_pin_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the timer counter core
// assumes tcc_core as the only slave and tcc_pin_model on chan_pin
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tcc_pkg::*;
  localparam logic [7:0] RUN = {3'h0, TCC_CLK_BUS, 3'h0};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  wire logic   chan_pin;
  logic        fixed_clk_tick;
  logic        debug_halt_mode;
  logic        overflow_irq;
  logic        chan_irq;
  logic [15:0] v;
  logic [15:0] b;
  logic [15:0] w;
  int          num_errors;
  int          n_compared;
  int          cyc = 0;

  tcc_core DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chan_pin(chan_pin), .fixed_clk_tick(fixed_clk_tick),
    .debug_halt_mode(debug_halt_mode), .overflow_irq(overflow_irq),
    .chan_irq(chan_irq)
  );
  tcc_pin_model pin_drv (.hclk(hclk), .chan_pin(chan_pin));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // fixed-clock tick every fourth cycle; cycle ceiling cuts a hang
  always @(posedge hclk) begin
    fixed_clk_tick <= (cyc % 4 == 0);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end

  // ********
  // bus and check tasks
  // ********
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00, d);
  endtask : rd

  task automatic rd16(input logic [7:0] ah, output logic [15:0] d);
    rd(ah, d[15:8]);
    rd(ah + 8'h04, d[7:0]);
  endtask : rd16

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // write one value byte, then read the whole value back
  task automatic wcv(input logic [7:0] a, input logic [7:0] d,
                     input logic [15:0] exp);
    wr(a, d);
    rd16(TCC_OFS_CVH, w);
    chk(w, exp);
  endtask : wcv

  // read while set, then write the config with the flag bit at 0
  task automatic clr(input logic [7:0] cfg);
    logic [7:0] x;
    rd(TCC_OFS_CCS, x);
    wr(TCC_OFS_CCS, cfg);
  endtask : clr

  task automatic run_cnt(input int n, output logic [15:0] c);
    wr(TCC_OFS_TCS, RUN);
    repeat (n) @(posedge hclk);
    wr(TCC_OFS_TCS, 8'h00);
    rd16(TCC_OFS_CNTH, c);
  endtask : run_cnt

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    logic [7:0] x;
    rd(TCC_OFS_TCS, x);
    chk(16'(x), 16'h0000);
    rd16(TCC_OFS_CVH, v);
    chk(v, 16'h0000);
    chk(16'(overflow_irq), 16'h0000);
    chk(16'(hresp), 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_clk;
    for (int c = 0; c < 4; c++) begin
      wr(TCC_OFS_CNTL, 8'h5a);
      wr(TCC_OFS_TCS, 8'(c << 3));
      if (c == 3)
        pin_drv.ext_clock(6);
      else
        repeat (40) @(posedge hclk);
      wr(TCC_OFS_TCS, 8'h00);
      rd16(TCC_OFS_CNTH, v);
      chk(16'(v != 16'h0000), 16'(c != 0));
      repeat (20) @(posedge hclk);
      rd16(TCC_OFS_CNTH, b);
      chk(b, v);
    end
    wr(TCC_OFS_CNTH, 8'h00);
    rd16(TCC_OFS_CNTH, v);
    chk(v, 16'h0000);
    $display("test clock select done");
  endtask : t_clk

  task automatic t_ovf;
    logic [7:0] x;
    int         k;
    wr(TCC_OFS_MODL, 8'h07);
    for (int cas = 0; cas < 2; cas++) begin
      wr(TCC_OFS_CNTL, 8'h00);
      wr(TCC_OFS_TCS, 8'(8'h40 | RUN | (cas << 5)));
      k = 0;
      while (overflow_irq !== 1'b1 && k < 60) begin
        @(posedge hclk);
        k++;
      end
      chk(16'(overflow_irq), 16'h0001);
      rd16(TCC_OFS_CNTH, v);
      chk(16'(v <= 16'h0007), 16'h0001);
      wr(TCC_OFS_TCS, 8'(8'h40 | (cas << 5)));
      rd(TCC_OFS_TCS, x);
      chk(16'(x[7]), 16'h0001);
      wr(TCC_OFS_TCS, 8'h00);
      wr(TCC_OFS_TCS, 8'h40);
      repeat (3) @(posedge hclk);
      chk(16'(overflow_irq), 16'h0000);
    end
    wr(TCC_OFS_MODL, 8'h00);
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_cap;
    logic [7:0] x;
    run_cnt(20, v);
    for (int c = 0; c < 4; c++) begin
      clr(8'(c << 2));
      pin_drv.set_level(1'b1);
      chk(16'(chan_irq), 16'(c & 1));
      clr(8'(c << 2));
      pin_drv.set_level(1'b0);
      chk(16'(chan_irq), 16'(c >> 1));
    end
    rd16(TCC_OFS_CVH, b);
    chk(b, v);
    wr(TCC_OFS_CVH, 8'hff);
    wcv(TCC_OFS_CVL, 8'hff, v);
    rd(TCC_OFS_CCS, x);
    pin_drv.set_level(1'b1);
    wr(TCC_OFS_CCS, 8'h0c);
    repeat (3) @(posedge hclk);
    chk(16'(chan_irq), 16'h0001);
    rd(TCC_OFS_CVH, x);
    run_cnt(20, b);
    debug_halt_mode <= 1'b1;
    pin_drv.set_level(1'b0);
    rd16(TCC_OFS_CVH, w);
    chk(w, b);
    debug_halt_mode <= 1'b0;
    rd(TCC_OFS_CVL, x);
    chk(16'(x), 16'(v[7:0]));
    rd16(TCC_OFS_CVH, w);
    chk(w, b);
    $display("test capture done");
  endtask : t_cap

  task automatic t_cmp;
    wr(TCC_OFS_CCS, 8'h10);
    wcv(TCC_OFS_CVH, 8'h12, b);
    wcv(TCC_OFS_CVL, 8'h34, 16'h1234);
    wr(TCC_OFS_CVL, 8'h78);
    wcv(TCC_OFS_CVH, 8'h56, 16'h5678);
    wr(TCC_OFS_CVH, 8'h9a);
    wr(TCC_OFS_CCS, 8'h10);
    wcv(TCC_OFS_CVL, 8'hbc, 16'h5678);
    wcv(TCC_OFS_CVH, 8'hde, 16'hdebc);
    wr(TCC_OFS_CVH, 8'h11);
    debug_halt_mode <= 1'b1;
    wcv(TCC_OFS_CVH, 8'h22, 16'h22bc);
    wcv(TCC_OFS_CVL, 8'h33, 16'h2233);
    debug_halt_mode <= 1'b0;
    wcv(TCC_OFS_CVL, 8'h44, 16'h1144);
    wr(TCC_OFS_TCS, RUN);
    wcv(TCC_OFS_CVH, 8'h01, 16'h1144);
    wcv(TCC_OFS_CVL, 8'h02, 16'h0102);
    wr(TCC_OFS_CCS, 8'h28);
    wr(TCC_OFS_MODL, 8'hff);
    wr(TCC_OFS_CNTL, 8'h00);
    wr(TCC_OFS_CVH, 8'h00);
    wcv(TCC_OFS_CVL, 8'h05, 16'h0102);
    repeat (300) @(posedge hclk);
    rd16(TCC_OFS_CVH, w);
    chk(w, 16'h0005);
    wr(TCC_OFS_TCS, 8'h00);
    $display("test compare done");
  endtask : t_cmp

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h00000000;
    fixed_clk_tick = 1'b0;
    debug_halt_mode = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_clk();
    t_ovf();
    t_cap();
    t_cmp();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
